// >>> rtl/dcs_supervisor.sv
/*
 charger safety supervisor: regulation target, latch, compatibility, insulation,
 overvoltage timing and fault shutdown, with a simple register port.
 assumes synchronous inputs, one clock at 125 MHz and an external link that moves register values.
*/
// Notes on behaviour
// - control fault stops current, cuts control supply
// - earth fault or overcurrent opens output conductor
// - regulate voltage or current, never both
// - clamp target to own maximum ratings
// - newest vehicle request retargets regulation
// - measure output voltage and current continuously
// - report measured values to the vehicle
// - latch engaged at 60 V rails or 28 V earth
// - no release above 60 V; safe disconnect allowed
// - hold latch until device commands release
// - flag broken latch drive or sense circuit
// - check compatibility from initialization parameters
// - own minimum below battery maximum, else terminate
// - incompatibility: shutdown, alarm, de-energize output
// - insulation check before contactors may close
// - insulation fail: error shutdown, charging refused
// - 400 ms overvoltage triggers shutdown within 10 ms
// - compare against latest vehicle voltage limit
// - output fault: open power, keep control supply
`include "dcs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dcs_supervisor
  import dcs_pkg::*;
#(
  parameter int unsigned OV_CYCLES = `DCS_OV_CYCLES,
  parameter int unsigned SD_CYCLES = `DCS_SD_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire dcs_meas_s   meas,
  input  wire dcs_faults_s faults,
  input  wire logic        insul_done,
  input  wire logic        insul_ok,
  input  wire logic        latch_sense,
  input  wire logic        latch_circuit_ok,
  output logic             insul_start,
  output logic             contactor_permit,
  output logic             power_enable,
  output logic             output_conn,
  output logic             ctrl_supply_en,
  output logic             latch_cmd,
  output logic             mode_cv,
  output logic      [15:0] target_v,
  output logic      [15:0] target_i,
  output logic             charge_refused,
  output logic             alarm
);
  ////////////////////////////////////////////////////////////////////////////
  dcs_state_e  state_r;
  dcs_state_e  state_nxt;
  logic [15:0] req_v_r;
  logic [15:0] req_i_r;
  logic [15:0] ev_vmax_r;
  logic [15:0] ev_batmax_r;
  logic [15:0] rate_vmax_r;
  logic [15:0] rate_imax_r;
  logic [15:0] rate_vmin_r;
  logic        connect_r;
  logic        mode_cv_r;
  logic        stop_r;
  logic        safe_rel_r;
  logic        compat_fail_r;
  logic        insul_fail_r;
  logic        ov_trip_r;
  logic        latch_fault_r;
  logic        ctrl_fault_r;
  logic        out_fault_r;
  logic [31:0] ov_cnt_r;
  logic [31:0] sd_cnt_r;
  logic        latch_r;
  logic [15:0] meas_v_r;
  logic [15:0] meas_i_r;
  logic        hv_present;
  logic        clr;
  logic        wr_ctrl;
  logic        ov_now;
  logic        out_fault_now;
  logic        fault_any;
  logic [15:0] clamp_v;
  logic [15:0] clamp_i;
  logic [5:0]  flag_set;
  wire  [5:0]  flag_r;

  assign wr_ctrl       = wr && (addr == `DCS_OFF_CTRL);
  assign clr           = wr_ctrl && wdata[`DCS_CTRL_CLR];
  assign ov_now        = (meas_v_r > ev_vmax_r);
  assign out_fault_now = faults.out_earth | faults.out_short | faults.overcurrent;
  assign fault_any     = ov_trip_r || (sd_cnt_r != 32'h0000_0000) || ctrl_fault_r ||
                         out_fault_r || latch_fault_r;
  assign hv_present    = (meas.volt >= `DCS_RAIL_LIM) || (meas.rail_p_earth >= `DCS_EARTH_LIM) ||
                         (meas.rail_n_earth >= `DCS_EARTH_LIM);

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_v_r     <= 16'h0000;
      req_i_r     <= 16'h0000;
      ev_vmax_r   <= 16'h0000;
      ev_batmax_r <= 16'h0000;
      rate_vmax_r <= `DCS_RST_RATE_VMAX;
      rate_imax_r <= `DCS_RST_RATE_IMAX;
      rate_vmin_r <= `DCS_RST_RATE_VMIN;
      connect_r   <= 1'b0;
      mode_cv_r   <= 1'b0;
      stop_r      <= 1'b0;
      safe_rel_r  <= 1'b0;
    end else begin
      if (wr) begin
        case (addr)
          `DCS_OFF_CTRL: begin
            connect_r  <= wdata[`DCS_CTRL_CONNECT];
            mode_cv_r  <= wdata[`DCS_CTRL_MODE_CV];
            stop_r     <= wdata[`DCS_CTRL_STOP];
            safe_rel_r <= wdata[`DCS_CTRL_SAFE_REL];
          end
          `DCS_OFF_REQ_V:     req_v_r     <= wdata;
          `DCS_OFF_REQ_I:     req_i_r     <= wdata;
          `DCS_OFF_EV_VMAX:   ev_vmax_r   <= wdata;
          `DCS_OFF_EV_BATMAX: ev_batmax_r <= wdata;
          `DCS_OFF_RATE_VMAX: rate_vmax_r <= wdata;
          `DCS_OFF_RATE_IMAX: rate_imax_r <= wdata;
          `DCS_OFF_RATE_VMIN: rate_vmin_r <= wdata;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement capture and read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_v_r <= 16'h0000;
      meas_i_r <= 16'h0000;
    end else begin
      meas_v_r <= meas.volt;
      meas_i_r <= meas.curr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `DCS_OFF_CTRL:      rdata <= {11'h000, safe_rel_r, 1'b0, stop_r, mode_cv_r, connect_r};
        `DCS_OFF_REQ_V:     rdata <= req_v_r;
        `DCS_OFF_REQ_I:     rdata <= req_i_r;
        `DCS_OFF_EV_VMAX:   rdata <= ev_vmax_r;
        `DCS_OFF_EV_BATMAX: rdata <= ev_batmax_r;
        `DCS_OFF_STATUS:    rdata <= {5'h00, hv_present, latch_r, ctrl_fault_r, out_fault_r, latch_fault_r,
                                      ov_trip_r, insul_fail_r, compat_fail_r, state_r};
        `DCS_OFF_MEAS_V:    rdata <= meas_v_r;
        `DCS_OFF_MEAS_I:    rdata <= meas_i_r;
        `DCS_OFF_RATE_VMAX: rdata <= rate_vmax_r;
        `DCS_OFF_RATE_IMAX: rdata <= rate_imax_r;
        `DCS_OFF_RATE_VMIN: rdata <= rate_vmin_r;
        default:            rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overvoltage duration and shutdown deadline
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_cnt_r <= 32'h0000_0000;
    end else if (state_r != DCS_CHARGE || !ov_now) begin
      ov_cnt_r <= 32'h0000_0000;
    end else if (ov_cnt_r < OV_CYCLES) begin
      ov_cnt_r <= ov_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_cnt_r <= 32'h0000_0000;
    end else if (ov_cnt_r >= OV_CYCLES && sd_cnt_r < SD_CYCLES) begin
      sd_cnt_r <= sd_cnt_r + 32'h0000_0001;
    end else if (ov_cnt_r < OV_CYCLES) begin
      sd_cnt_r <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky fault flags: set wins over clear
  assign flag_set = {out_fault_now,
                     faults.ctrl_fault,
                     !latch_circuit_ok || (latch_cmd && !latch_sense),
                     ov_cnt_r >= OV_CYCLES,
                     state_r == DCS_INSUL && insul_done && !insul_ok,
                     state_r == DCS_COMPAT && rate_vmin_r >= ev_batmax_r};

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_flag
      logic bit_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          bit_r <= 1'b0;
        end else begin
          bit_r <= flag_set[g] || (bit_r && !clr);
        end
      end
      assign flag_r[g] = bit_r;
    end
  endgenerate

  assign compat_fail_r = flag_r[0];
  assign insul_fail_r  = flag_r[1];
  assign ov_trip_r     = flag_r[2];
  assign latch_fault_r = flag_r[3];
  assign ctrl_fault_r  = flag_r[4];
  assign out_fault_r   = flag_r[5];

  ////////////////////////////////////////////////////////////////////////////
  // charge sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DCS_IDLE: begin
        if (connect_r && !stop_r) begin
          state_nxt = DCS_COMPAT;
        end
      end
      DCS_COMPAT: begin
        if (rate_vmin_r >= ev_batmax_r) begin
          state_nxt = DCS_ERROR;
        end else begin
          state_nxt = DCS_INSUL;
        end
      end
      DCS_INSUL: begin
        if (insul_done && insul_ok) begin
          state_nxt = DCS_CHARGE;
        end else if (insul_done) begin
          state_nxt = DCS_ERROR;
        end
      end
      DCS_CHARGE: begin
        if (stop_r || !connect_r) begin
          state_nxt = DCS_SHUTDOWN;
        end
      end
      DCS_SHUTDOWN: begin
        if (!connect_r && !hv_present) begin
          state_nxt = DCS_IDLE;
        end
      end
      DCS_ERROR: begin
        if (clr && !hv_present) begin
          state_nxt = DCS_IDLE;
        end
      end
      default: begin
        state_nxt = DCS_IDLE;
      end
    endcase
    // deadline counter backs up the trip flag
    if (state_r != DCS_IDLE && state_r != DCS_ERROR && fault_any) begin
      state_nxt = DCS_ERROR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= DCS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch: engages on connect, held until idle, voltage gone and connect cleared; with voltage present, safe release and no latch fault open it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= 1'b0;
    end else if (hv_present) begin
      latch_r <= !safe_rel_r || latch_fault_r ? 1'b1 : 1'b0;
    end else if (state_r != DCS_IDLE) begin
      latch_r <= 1'b1;
    end else if (!connect_r) begin
      latch_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    clamp_v = req_v_r;
    if (req_v_r > rate_vmax_r) begin
      clamp_v = rate_vmax_r;
    end
  end

  always_comb begin
    clamp_i = req_i_r;
    if (req_i_r > rate_imax_r) begin
      clamp_i = rate_imax_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_cv <= 1'b0;
    end else begin
      mode_cv <= mode_cv_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_v <= 16'h0000;
    end else begin
      target_v <= clamp_v;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_i <= 16'h0000;
    end else begin
      target_i <= clamp_i;
    end
  end

  assign latch_cmd        = latch_r;
  assign insul_start      = (state_r == DCS_INSUL);
  assign contactor_permit = (state_r == DCS_CHARGE) && !insul_fail_r;
  assign power_enable     = (state_r == DCS_CHARGE) && !ov_trip_r && !ctrl_fault_r && !out_fault_r;
  assign output_conn      = power_enable && !out_fault_now;
  assign ctrl_supply_en   = !ctrl_fault_r;
  assign charge_refused   = insul_fail_r || compat_fail_r;
  assign alarm            = (state_r == DCS_ERROR);
endmodule : dcs_supervisor
`default_nettype wire

// >>> rtl/dcs_params.svh
/*
 constants for the charger safety supervisor: register offsets, reset values, timing counts.
 assumes a 125 MHz clock; measured values are unsigned codes in 0.1 V / 0.1 A units.
*/
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH
`define DCS_CLK_MHZ        125
`define DCS_OV_TIME_MS     400
`define DCS_OV_CYCLES      (`DCS_OV_TIME_MS * 1000 * `DCS_CLK_MHZ)
`define DCS_SD_TIME_MS     10
`define DCS_SD_CYCLES      (`DCS_SD_TIME_MS * 1000 * `DCS_CLK_MHZ)
`define DCS_RAIL_LIM       16'd600
`define DCS_EARTH_LIM      16'd280
`define DCS_OFF_CTRL       4'h0
`define DCS_OFF_REQ_V      4'h1
`define DCS_OFF_REQ_I      4'h2
`define DCS_OFF_EV_VMAX    4'h3
`define DCS_OFF_EV_BATMAX  4'h4
`define DCS_OFF_STATUS     4'h5
`define DCS_OFF_MEAS_V     4'h6
`define DCS_OFF_MEAS_I     4'h7
`define DCS_OFF_RATE_VMAX  4'h8
`define DCS_OFF_RATE_IMAX  4'h9
`define DCS_OFF_RATE_VMIN  4'ha
`define DCS_CTRL_CONNECT   0
`define DCS_CTRL_MODE_CV   1
`define DCS_CTRL_STOP      2
`define DCS_CTRL_CLR       3
`define DCS_CTRL_SAFE_REL  4
`define DCS_RST_RATE_VMAX  16'd5000
`define DCS_RST_RATE_IMAX  16'd2000
`define DCS_RST_RATE_VMIN  16'd1500
`endif

// >>> rtl/dcs_pkg.sv
/*
 types for the charger safety supervisor.
 assumes dcs_params.svh is on the include path.
*/
package dcs_pkg;
  typedef enum logic [2:0] {
    DCS_IDLE     = 3'b000,
    DCS_COMPAT   = 3'b001,
    DCS_INSUL    = 3'b010,
    DCS_CHARGE   = 3'b011,
    DCS_SHUTDOWN = 3'b100,
    DCS_ERROR    = 3'b101
  } dcs_state_e;
  typedef struct packed {
    logic ctrl_fault;
    logic out_earth;
    logic out_short;
    logic overcurrent;
  } dcs_faults_s;
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] rail_p_earth;
    logic [15:0] rail_n_earth;
  } dcs_meas_s;
endpackage : dcs_pkg

// >>> verif/dcs_veh_model.sv
/* vehicle-side model: insulation answer and latch feedback.
 assumes dcs_supervisor ports and one clock. */
`timescale 1ns/1ps
`default_nettype none
module dcs_veh_model #(
  parameter int DLY = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic insul_start,
  input  wire logic latch_cmd,
  input  wire logic pass,
  output logic      insul_done,
  output logic      insul_ok,
  output logic      latch_sense
);
  int cnt;
  assign latch_sense = latch_cmd;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= 0;
    else cnt <= insul_start ? cnt + 1 : 0;
  end
  assign insul_done = insul_start && cnt >= DLY;
  // result line shows the inverse while no answer stands
  assign insul_ok = insul_done ? pass : ~pass;
endmodule : dcs_veh_model
`default_nettype wire

// >>> verif/dcs_supervisor_properties.sv
/* port checker for dcs_supervisor.
 assumes rating registers keep their reset values. */
`include "dcs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dcs_supervisor_properties
  import dcs_pkg::*;
#(
  parameter int unsigned OV_CYCLES = 40
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire dcs_meas_s   meas,
  input wire dcs_faults_s faults,
  input wire logic        insul_start,
  input wire logic        contactor_permit,
  input wire logic        power_enable,
  input wire logic        output_conn,
  input wire logic        ctrl_supply_en,
  input wire logic        latch_cmd,
  input wire logic [15:0] target_v,
  input wire logic        alarm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] vmax_r;
  int unsigned ov_cnt_r;
  logic        hv;
  logic        ofault;
  logic        srel_r;
  assign hv = meas.volt >= `DCS_RAIL_LIM || meas.rail_p_earth >= `DCS_EARTH_LIM
              || meas.rail_n_earth >= `DCS_EARTH_LIM;
  assign ofault = faults.out_earth || faults.out_short || faults.overcurrent;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) vmax_r <= '0;
    else if (wr && addr == `DCS_OFF_EV_VMAX) vmax_r <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) srel_r <= 1'b0;
    else if (wr && addr == `DCS_OFF_CTRL) srel_r <= wdata[`DCS_CTRL_SAFE_REL];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ov_cnt_r <= 0;
    else ov_cnt_r <= (power_enable && meas.volt > vmax_r) ? ov_cnt_r + 1 : 0;
  end
  a_ctrl_fault_cut: assert property (faults.ctrl_fault |=> !ctrl_supply_en && !power_enable)
    else $error("control fault left supply or power on");
  a_out_fault_open: assert property (ofault |-> !output_conn)
    else $error("output stayed connected during fault");
  a_supply_kept: assert property ((ofault && ctrl_supply_en) ##1 !faults.ctrl_fault |-> ctrl_supply_en)
    else $error("control supply dropped on output fault");
  a_clamp_volt: assert property (wr && addr == `DCS_OFF_REQ_V && wdata > `DCS_RST_RATE_VMAX
    |-> ##[1:3] target_v == `DCS_RST_RATE_VMAX)
    else $error("voltage target not clamped");
  a_latch_on_hv: assert property ((hv && !srel_r) [*3] |-> latch_cmd)
    else $error("latch open with voltage present");
  a_latch_hold: assert property (latch_cmd && hv && !srel_r |=> latch_cmd)
    else $error("latch released with voltage present");
  a_insul_first: assert property ($rose(contactor_permit) |-> $past(insul_start))
    else $error("contactors permitted without insulation check");
  a_ov_bound: assert property (ov_cnt_r <= OV_CYCLES + 5)
    else $error("overvoltage not shut down in time");
  c_alarm: cover property ($rose(alarm));
  c_permit: cover property ($rose(contactor_permit));
  c_supply_cut: cover property ($fell(ctrl_supply_en));
  c_safe_rel: cover property (srel_r && hv && !latch_cmd);
endmodule : dcs_supervisor_properties
bind dcs_supervisor dcs_supervisor_properties #(.OV_CYCLES(OV_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .meas(meas), .faults(faults),
  .insul_start(insul_start), .contactor_permit(contactor_permit), .power_enable(power_enable),
  .output_conn(output_conn), .ctrl_supply_en(ctrl_supply_en), .latch_cmd(latch_cmd),
  .target_v(target_v), .alarm(alarm));
`default_nettype wire

// >>> verif/dcs_supervisor_tb.sv
/* self-checking bench for dcs_supervisor with the vehicle model.
 assumes 125 MHz clock and shortened overvoltage count. */
`include "dcs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dcs_supervisor_tb
  import dcs_pkg::*;
;
  localparam int OVC = 40;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rd_q = 0, pass = 1, lok = 1;
  logic [3:0]  addr = '0;
  logic [15:0] wdata = '0, rdata, target_v, target_i;
  logic [31:0] seed = 32'h92c6c357;
  dcs_meas_s   meas = '{16'd0, 16'd100, 16'd0, 16'd0};
  dcs_faults_s faults = '0;
  logic insul_done, insul_ok, latch_sense, insul_start, contactor_permit, power_enable;
  logic output_conn, ctrl_supply_en, latch_cmd, mode_cv, charge_refused, alarm;
  logic [15:0] expq[$];
  int          fails = 0, tests_run = 0;
  always #4 clk = ~clk;
  dcs_supervisor #(.OV_CYCLES(OVC), .SD_CYCLES(10)) dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .meas(meas), .faults(faults),
    .insul_done(insul_done), .insul_ok(insul_ok), .latch_sense(latch_sense), .latch_circuit_ok(lok),
    .insul_start(insul_start), .contactor_permit(contactor_permit), .power_enable(power_enable),
    .output_conn(output_conn), .ctrl_supply_en(ctrl_supply_en), .latch_cmd(latch_cmd),
    .mode_cv(mode_cv), .target_v(target_v), .target_i(target_i), .charge_refused(charge_refused),
    .alarm(alarm));
  dcs_veh_model u_veh (.clk(clk), .rst_n(rst_n), .insul_start(insul_start), .latch_cmd(latch_cmd),
    .pass(pass), .insul_done(insul_done), .insul_ok(insul_ok), .latch_sense(latch_sense));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic setv(input logic [15:0] v, input int n);
    @(posedge clk);
    meas.volt <= v;
    cyc(n);
  endtask : setv
  task automatic start_charge();
    wreg(`DCS_OFF_EV_BATMAX, 16'd4000);
    wreg(`DCS_OFF_EV_VMAX, 16'd4000);
    wreg(`DCS_OFF_CTRL, 16'h1);
    cyc(12);
  endtask : start_charge
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q && expq.size() > 0) chk(rdata, expq.pop_front());
  end
  initial begin
    cyc(20000);
    fails++;
    conclude();
  end
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    rreg(`DCS_OFF_RATE_VMAX, `DCS_RST_RATE_VMAX);
    rreg(`DCS_OFF_RATE_IMAX, `DCS_RST_RATE_IMAX);
    rreg(`DCS_OFF_RATE_VMIN, `DCS_RST_RATE_VMIN);
    rreg(4'hb, 16'h0);
    $display("done registers");
    wreg(`DCS_OFF_REQ_V, 16'd6000);
    cyc(3);
    chk(target_v, `DCS_RST_RATE_VMAX);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wreg(`DCS_OFF_REQ_I, {6'h0, seed[9:0]});
      cyc(3);
      chk(target_i, {6'h0, seed[9:0]});
    end
    wreg(`DCS_OFF_CTRL, 16'h2);
    cyc(3);
    chk(16'(mode_cv), 16'h1);
    wreg(`DCS_OFF_CTRL, 16'h0);
    cyc(3);
    chk(16'(mode_cv), 16'h0);
    $display("done targets");
    wreg(`DCS_OFF_EV_BATMAX, 16'd1000);
    wreg(`DCS_OFF_CTRL, 16'h1);
    cyc(6);
    chk(16'(alarm), 16'h1);
    chk(16'(output_conn), 16'h0);
    rreg(`DCS_OFF_STATUS, 16'h020d);
    wreg(`DCS_OFF_CTRL, 16'h8);
    cyc(4);
    chk(16'(alarm), 16'h0);
    $display("done compatibility");
    start_charge();
    chk(16'(contactor_permit), 16'h1);
    setv(16'd3000, 2);
    rreg(`DCS_OFF_MEAS_V, 16'd3000);
    rreg(`DCS_OFF_MEAS_I, 16'd100);
    setv(16'd4100, OVC - 10);
    setv(16'd3000, 3);
    setv(16'd4100, OVC - 10);
    chk(16'(alarm), 16'h0);
    wreg(`DCS_OFF_EV_VMAX, 16'd4200);
    cyc(2 * OVC);
    chk(16'(alarm), 16'h0);
    setv(16'd4300, OVC + 10);
    chk(16'(alarm), 16'h1);
    chk(16'(power_enable), 16'h0);
    chk(16'(latch_cmd), 16'h1);
    setv(16'd0, 3);
    wreg(`DCS_OFF_CTRL, 16'h8);
    cyc(4);
    chk(16'(latch_cmd), 16'h0);
    $display("done overvoltage");
    start_charge();
    @(posedge clk);
    faults.out_earth <= 1'b1;
    cyc(3);
    chk(16'(output_conn), 16'h0);
    chk(16'(ctrl_supply_en), 16'h1);
    faults.ctrl_fault <= 1'b1;
    cyc(3);
    chk(16'(ctrl_supply_en), 16'h0);
    faults <= '0;
    wreg(`DCS_OFF_CTRL, 16'h8);
    cyc(4);
    chk(16'(ctrl_supply_en), 16'h1);
    $display("done faults");
    pass <= 1'b0;
    start_charge();
    chk(16'(charge_refused), 16'h1);
    chk(16'(contactor_permit), 16'h0);
    $display("done insulation");
    setv(16'd3000, 3);
    wreg(`DCS_OFF_CTRL, 16'h10);
    cyc(3);
    chk(16'(latch_cmd), 16'h0);
    lok <= 1'b0;
    cyc(3);
    chk(16'(latch_cmd), 16'h1);
    $display("done latch");
    conclude();
  end
endmodule : dcs_supervisor_tb
`default_nettype wire
